// ### design/cmp_out_pkg.sv
// Package: register map, field positions and constants of the comparator block
package cmp_out_pkg;
  // Register byte offsets (one aligned word each)
  localparam logic [7:0] ctrl_off       = 8'h00; // Control register
  localparam logic [7:0] threshold_off  = 8'h04; // Threshold code register
  localparam logic [7:0] status_off     = 8'h08; // Status register
  // Control field positions
  localparam int module_enable_bit    = 15;
  localparam int halt_idle_bit        = 13;
  localparam int hys_amount_lsb       = 11;
  localparam int filter_enable_bit    = 10;
  localparam int filter_clk_bit       = 9;
  localparam int dac_oe_bit           = 8;
  localparam int source_sel_lsb       = 6;
  localparam int ext_ref_bit          = 5;
  localparam int hys_edge_bit         = 4;
  localparam int state_bit            = 3;
  localparam int alt_source_bit       = 2;
  localparam int invert_bit           = 1;
  localparam int range_bit            = 0;
  // Writable bits of the control register (bit 14 and bit 3 excluded)
  localparam logic [15:0] ctrl_wmask  = 16'hbff7;
  localparam logic [15:0] ctrl_reset  = 16'h0000;
  localparam logic [11:0] dac_reset   = 12'h000;
  // Timing
  localparam int stretch_min_cycles   = 3;
  localparam int filter_stable_cycles = 3;
  // Source select codes
  localparam logic [5:0] src_none     = 6'h00;
  // Hysteresis amount codes: 0 none, 1 5mV, 2 10mV, 3 20mV
  localparam logic [1:0] hys_off      = 2'h0;
  localparam logic [1:0] hys_5mv      = 2'h1;
  localparam logic [1:0] hys_10mv     = 2'h2;
  localparam logic [1:0] hys_20mv     = 2'h3;
  // Analog control bundle
  typedef struct packed {
    logic [5:0]  source_onehot;  // A,B,C,D,gain1,gain2
    logic [11:0] dac_code;
    logic        ext_reference_select;
    logic        avdd_reference;
    logic        dac_pin_output_enable;
    logic [1:0]  hysteresis_amount_select;
    logic        hysteresis_edge_select;
    logic        analog_enable;
  } analog_ctrl_t;
  // Output consumer bundle
  typedef struct packed {
    logic irq;
    logic adc_trigger;
    logic pwm_duty_trunc;
    logic pwm_period_trunc;
    logic pwm_fault;
    logic wake;
  } consumer_t;
  // Bus state
  typedef enum logic [1:0] {
    bus_idle  = 2'b01,
    bus_write = 2'b10
  } bus_state_t;
endpackage

// ### design/cmp_out_logic.sv
// Comparator channel: register slave, input/DAC control, output conditioning
//
// Function
// R1 - Inverting input fixed to threshold DAC
// R2 - Six positive sources: four pins, two amplifiers
// R3 - Own 12-bit DAC code from register
// R4 - Reference: external, or internal/supply via range
// R5 - DAC pin driven only when enabled
// R6 - Software enables one DAC pin per pin
// R7 - Polarity applied before pulse stretcher
// R8 - Stretcher sets async, holds three cycles
// R9 - Filter after stretcher, bypassed unless enabled
// R10 - Filter clocked by selected clock
// R11 - Filter output changes after three stable
// R12 - Hysteresis off, 5, 10, 20 mV
// R13 - Hysteresis on rising or falling edge
// R14 - Output fans out to five consumers
// R15 - Threshold crossing may wake system
// R16 - Clock select one means PWM clock
// R17 - Source decode pins or amplifiers, reserved
// R18 - Read-only status shows polarised output
// R19 - Any halt-in-idle bit halts in Idle
// R20 - Output synchronised before status and interrupt
// R21 - Disabled module holds outputs inactive
`timescale 1ns/10ps
module cmp_out_logic
  import cmp_out_pkg::*;
(
  input  wire logic        clk,               // System clock 20 MHz
  input  wire logic        nrst,              // Async reset, active low
  input  wire logic        ce,                // Clock enable, freezes state except the async stretcher set
  input  wire logic        pwm_clk_tick,      // PWM clock as sync enable
  input  wire logic        idle_mode,         // Device in Idle
  input  wire logic        sleep_mode,        // Device in Sleep
  input  wire logic        other_halt_idle,   // OR of other halt bits
  input  wire logic        raw_compare,       // Analog comparator result
  input  wire logic        hsel,              // AHB-Lite select
  input  wire logic [31:0] haddr,             // AHB-Lite address
  input  wire logic [1:0]  htrans,            // AHB-Lite transfer type
  input  wire logic        hwrite,            // AHB-Lite write
  input  wire logic [2:0]  hsize,             // AHB-Lite size
  input  wire logic [31:0] hwdata,            // AHB-Lite write data
  input  wire logic        hready,            // AHB-Lite bus ready
  output logic      [31:0] hrdata,            // AHB-Lite read data
  output logic             hreadyout,         // AHB-Lite slave ready
  output logic             hresp,             // AHB-Lite response
  output analog_ctrl_t     analog_ctrl,       // To analog macro
  output logic             halt_in_idle,      // This channel halt bit
  output consumer_t        consumers          // Conditioned output fanout
);

  // Assertions below share the system clock and its reset
  default clocking sys_cb @(posedge clk); endclocking
  default disable iff (!nrst);

  // Decoding of a byte offset to a register select, used for writes and reads
  function automatic logic [2:0] reg_sel(input logic [7:0] off);
    reg_sel = {off == status_off, off == threshold_off, off == ctrl_off};
  endfunction

  // ---------------- Bus slave ----------------
  logic [15:0] comparator_control_register_r; // Control register
  logic [15:0] comparator_control_register_nxt;
  logic [11:0] threshold_code_register_r;     // DAC code
  logic [11:0] threshold_code_register_nxt;
  bus_state_t  bus_r;                          // Pending write phase
  bus_state_t  bus_nxt;
  logic [2:0]  wsel_r;                         // Latched write select
  logic [2:0]  wsel_nxt;
  logic [31:0] hrdata_r;                       // Registered read data
  logic [31:0] hrdata_nxt;
  logic        addr_phase;                     // Valid address phase
  logic        comparator_output_state;        // Polarised, synced state

  assign addr_phase = hsel && hready && htrans[1];
  assign hreadyout  = 1'b1;  // Zero wait states
  assign hresp      = 1'b0;  // Always OKAY, unmapped reads zero
  assign hrdata     = hrdata_r;

  // Next values of the register file and bus tracking
  always_comb begin
    logic [2:0] rs;
    rs = reg_sel(haddr[7:0]);
    comparator_control_register_nxt = comparator_control_register_r;
    threshold_code_register_nxt     = threshold_code_register_r;
    bus_nxt    = bus_idle;
    wsel_nxt   = 3'h0;
    hrdata_nxt = hrdata_r;
    // Data phase of a write: commit into the latched register
    if (bus_r == bus_write) begin
      if (wsel_r[0]) begin
        comparator_control_register_nxt =
          (hwdata[15:0] & ctrl_wmask) |
          (comparator_control_register_r & ~ctrl_wmask);
      end
      if (wsel_r[1]) begin
        threshold_code_register_nxt = hwdata[11:0]; // R3
      end
    end
    // Address phase: latch write target or prepare read word
    if (addr_phase) begin
      if (hwrite) begin
        bus_nxt  = bus_write;
        wsel_nxt = (haddr[31:8] == 24'h000000) ? rs : 3'h0;
      end else if (haddr[31:8] != 24'h000000) begin
        hrdata_nxt = 32'h0000_0000;
      end else if (rs[0]) begin
        hrdata_nxt = {16'h0000, comparator_control_register_r[15:4],
                      comparator_output_state,              // R18
                      comparator_control_register_r[2:0]};
      end else if (rs[1]) begin
        hrdata_nxt = {20'h00000, threshold_code_register_r};
      end else if (rs[2]) begin
        hrdata_nxt = {31'h0, comparator_output_state};      // R18
      end else begin
        hrdata_nxt = 32'h0000_0000;
      end
    end
  end

  // Registers of the bus slave
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      comparator_control_register_r <= ctrl_reset;
      threshold_code_register_r     <= dac_reset;
      bus_r    <= bus_idle;
      wsel_r   <= 3'h0;
      hrdata_r <= 32'h0000_0000;
    end else if (ce) begin
      comparator_control_register_r <= comparator_control_register_nxt;
      threshold_code_register_r     <= threshold_code_register_nxt;
      bus_r    <= bus_nxt;
      wsel_r   <= wsel_nxt;
      hrdata_r <= hrdata_nxt;
    end
  end

  // ---------------- Control field decode ----------------
  logic       comparator_module_enable;
  logic       glitch_filter_enable;
  logic       filter_clock_select;
  logic       alternate_source_enable;
  logic       output_invert;
  logic [1:0] positive_source_select;
  logic       running;                  // Enabled and not halted

  assign comparator_module_enable =
    comparator_control_register_r[module_enable_bit];
  assign halt_in_idle = comparator_control_register_r[halt_idle_bit];
  assign glitch_filter_enable =
    comparator_control_register_r[filter_enable_bit];
  assign filter_clock_select =
    comparator_control_register_r[filter_clk_bit];
  assign alternate_source_enable =
    comparator_control_register_r[alt_source_bit];
  assign output_invert = comparator_control_register_r[invert_bit];
  assign positive_source_select =
    comparator_control_register_r[source_sel_lsb +: 2];
  // Any channel's halt bit stops all channels in Idle
  assign running = comparator_module_enable &&
    !(idle_mode && (halt_in_idle || other_halt_idle));              // R19

  // Analog control: source mux, DAC code, reference, pin, hysteresis
  always_comb begin
    analog_ctrl.source_onehot = src_none;
    if (running) begin
      if (!alternate_source_enable) begin
        analog_ctrl.source_onehot[positive_source_select] = 1'b1; // R17 R2
      end else if (!positive_source_select[1]) begin
        // Codes 10 and 11 are reserved and leave the input open
        analog_ctrl.source_onehot[4 + positive_source_select[0]] = 1'b1;
      end
    end
    analog_ctrl.dac_code = threshold_code_register_r;            // R1 R3
    analog_ctrl.ext_reference_select =
      comparator_control_register_r[ext_ref_bit];                // R4
    analog_ctrl.avdd_reference =
      !comparator_control_register_r[ext_ref_bit] &&
      comparator_control_register_r[range_bit];                  // R4
    analog_ctrl.dac_pin_output_enable =
      comparator_control_register_r[dac_oe_bit];                 // R5
    analog_ctrl.hysteresis_amount_select =
      comparator_control_register_r[hys_amount_lsb +: 2];        // R12
    analog_ctrl.hysteresis_edge_select =
      comparator_control_register_r[hys_edge_bit];               // R13
    analog_ctrl.analog_enable = running;
  end

  // ---------------- Output conditioning ----------------
  logic       polarised;      // Raw result after polarity
  logic       stretch_set;    // Async set of the stretcher
  logic       stretch_r;      // Stretcher latch
  logic [1:0] stretch_cnt_r;  // Hold counter
  logic [1:0] stretch_cnt_nxt;
  logic       stretch_out;    // Stretched level
  logic       sync1_r;        // Synchroniser stage 1
  logic       sync2_r;        // Synchroniser stage 2
  logic       step;           // Selected filter clock edge
  logic [1:0] flt_cnt_r;      // Stable-sample count
  logic [1:0] flt_cnt_nxt;
  logic       flt_r;          // Filtered level
  logic       flt_nxt;
  logic       cond_out;       // Conditioned output

  assign polarised   = (raw_compare ^ output_invert) && running; // R7 R21
  assign stretch_set = polarised;
  assign stretch_out = stretch_r | polarised;                  // R8
  // Filter and stretcher step on the PWM tick or every clock
  assign step = filter_clock_select ? pwm_clk_tick : 1'b1;     // R10 R16

  // Stretcher latch: a narrow event sets it without a clock
  always_ff @(posedge clk or posedge stretch_set or negedge nrst) begin
    if (!nrst) begin
      stretch_r <= 1'b0;
    end else if (stretch_set) begin
      stretch_r <= 1'b1;                                       // R8
    end else if (ce && step && stretch_cnt_r == 2'(stretch_min_cycles-1)) begin
      stretch_r <= 1'b0;
    end
  end

  // Hold counter: restarts on every new set, releases after three steps
  always_comb begin
    stretch_cnt_nxt = stretch_cnt_r;
    if (polarised || !stretch_r) begin
      stretch_cnt_nxt = 2'h0;
    end else if (step && stretch_cnt_r != 2'(stretch_min_cycles - 1)) begin
      stretch_cnt_nxt = stretch_cnt_r + 2'h1;                  // R8
    end
  end

  // Synchroniser into the system clock; stage 1 feeds stage 2 only
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      stretch_cnt_r <= 2'h0;
      sync1_r       <= 1'b0;
      sync2_r       <= 1'b0;
    end else if (ce) begin
      stretch_cnt_r <= stretch_cnt_nxt;
      sync1_r       <= stretch_out;                            // R20
      sync2_r       <= sync1_r;                                // R20
    end
  end

  // Glitch filter: output follows after three equal samples
  always_comb begin
    flt_cnt_nxt = flt_cnt_r;
    flt_nxt     = flt_r;
    if (step) begin
      if (sync2_r == flt_r) begin
        flt_cnt_nxt = 2'h0;
      end else if (flt_cnt_r == 2'(filter_stable_cycles - 1)) begin
        flt_nxt     = sync2_r;                                 // R11
        flt_cnt_nxt = 2'h0;
      end else begin
        flt_cnt_nxt = flt_cnt_r + 2'h1;
      end
    end
  end

  // Filter registers
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      flt_cnt_r <= 2'h0;
      flt_r     <= 1'b0;
    end else if (ce) begin
      flt_cnt_r <= flt_cnt_nxt;
      flt_r     <= flt_nxt;
    end
  end

  // Filter is bypassed unless enabled; disabled module forces low
  assign cond_out = running &&
    (glitch_filter_enable ? flt_r : sync2_r);                  // R9 R21
  assign comparator_output_state = cond_out;                   // R18

  // Fan out to every consumer at once
  always_comb begin
    consumers.irq              = cond_out;                     // R14
    consumers.adc_trigger      = cond_out;                     // R14
    consumers.pwm_duty_trunc   = cond_out;                     // R14
    consumers.pwm_period_trunc = cond_out;                     // R14
    consumers.pwm_fault        = cond_out;                     // R14
    // Wake from Sleep or Idle on a threshold crossing
    consumers.wake = (sleep_mode || idle_mode) && cond_out;    // R15
  end

  // ---------------- Assertions ----------------
  sequence s_stretch_hold;
    stretch_r ##1 stretch_r;
  endsequence
  property p_filter_holds;
    ce && sync2_r != flt_r && flt_cnt_r != 2'h2 |=> $stable(flt_r);
  endproperty
  a_filter_holds: assert property (p_filter_holds) // R11
    else $error("filter output changed too early");
  property p_filter_moves;
    ce && step && sync2_r != flt_r && flt_cnt_r == 2'h2 |=> $changed(flt_r);
  endproperty
  a_filter_moves: assert property (p_filter_moves) // R11
    else $error("filter output failed to follow stable input");
  property p_bypass;
    running && !glitch_filter_enable |-> cond_out == sync2_r;
  endproperty
  a_bypass: assert property (p_bypass) // R9
    else $error("unfiltered path not a bypass");
  property p_disabled;
    !comparator_module_enable |-> !cond_out && !consumers.irq;
  endproperty
  a_disabled: assert property (p_disabled) // R21
    else $error("outputs active while disabled");
  property p_sync_delay;
    ce ##1 ce ##1 1'b1 |-> sync2_r == $past(stretch_out, 2);
  endproperty
  a_sync_delay: assert property (p_sync_delay) // R20
    else $error("synchroniser delay wrong");
  property p_stretch_min;
    $rose(stretch_r) |=> s_stretch_hold;
  endproperty
  a_stretch_min: assert property (p_stretch_min) // R8
    else $error("stretched pulse too short");
  property p_dac_oe;
    analog_ctrl.dac_pin_output_enable ==
    comparator_control_register_r[dac_oe_bit];
  endproperty
  a_dac_oe: assert property (p_dac_oe) // R5
    else $error("DAC pin enable mismatch");
  property p_reserved_src;
    alternate_source_enable && positive_source_select[1]
    |-> analog_ctrl.source_onehot == src_none;
  endproperty
  a_reserved_src: assert property (p_reserved_src) // R17
    else $error("reserved source code selected an input");
  property p_idle_halt;
    idle_mode && other_halt_idle |-> !analog_ctrl.analog_enable && !cond_out;
  endproperty
  a_idle_halt: assert property (p_idle_halt) // R19
    else $error("comparator ran in Idle while halted");
endmodule

// ### tb/cmp_far_model.sv
// Far-side model: analog comparator result and PWM clock ticks
`timescale 1ns/10ps
module cmp_far_model #(
  parameter int tick_period = 8              // PWM tick spacing in clocks
) (
  input  wire logic clk,                     // System clock
  input  wire logic nrst,                    // Async reset, active low
  input  wire logic analog_level,            // Steady comparator level
  input  wire logic glitch_req,              // Rise asks for a narrow pulse
  output logic      raw_compare,             // Comparator result
  output logic      pwm_clk_tick             // PWM clock enable pulse
);
  logic       glitch;                        // Pulse shorter than a clock
  logic [7:0] tick_cnt_r;                    // Tick divider
  logic [7:0] tick_cnt_nxt;                  // Next divider value
  // Narrow pulse placed between edges, so only an async set can catch it
  initial glitch = 1'b0;
  always @(posedge glitch_req) begin
    #5 glitch = 1'b1;
    #10 glitch = 1'b0;
  end
  assign raw_compare = analog_level | glitch;
  // Divider wraps so ticks stay evenly spaced
  always_comb begin
    tick_cnt_nxt = tick_cnt_r + 8'h01;
    if (tick_cnt_r == 8'(tick_period - 1)) begin
      tick_cnt_nxt = 8'h00;
    end
  end
  // Divider register
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tick_cnt_r <= 8'h00;
    end else begin
      tick_cnt_r <= tick_cnt_nxt;
    end
  end
  assign pwm_clk_tick = (tick_cnt_r == 8'h00);
endmodule

// ### tb/hs_comparator_output_logic_test.sv
// Testbench: register access, source decode and output conditioning
`timescale 1ns/10ps
module hs_comparator_output_logic_test;
  import cmp_out_pkg::*;
  logic         clk;                 // System clock
  logic         nrst;                // Reset, active low
  logic         pwm_clk_tick;        // From far-side model
  logic         raw_compare;         // From far-side model
  logic         analog_level;        // Steady analog result
  logic         glitch_req;          // Narrow pulse request
  logic         idle_mode;           // Power state Idle
  logic         sleep_mode;          // Power state Sleep
  logic         other_halt_idle;     // Halt bit of other channels
  logic         hsel;                // Bus select
  logic [31:0]  haddr;               // Bus address
  logic [1:0]   htrans;              // Bus transfer type
  logic         hwrite;              // Bus direction
  logic [2:0]   hsize;               // Bus size
  logic [31:0]  hwdata;              // Bus write data
  logic [31:0]  hrdata;              // Bus read data
  logic         hreadyout;           // Slave ready, also bus ready
  logic         hresp;               // Slave response
  analog_ctrl_t analog_ctrl;         // Analog controls
  logic         halt_in_idle;        // Own halt bit
  consumer_t    consumers;           // Conditioned output fanout
  int           n_errors;            // Mismatch count
  int           total_checks;        // Comparison count
  int           cyc;                 // Cycles since start, for timeout
  int           n;                   // Latency measured
  cmp_out_logic u_cmp_out_logic (.clk(clk), .nrst(nrst), .ce(1'b1),
    .pwm_clk_tick(pwm_clk_tick), .idle_mode(idle_mode),
    .sleep_mode(sleep_mode), .other_halt_idle(other_halt_idle),
    .raw_compare(raw_compare), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .analog_ctrl(analog_ctrl),
    .halt_in_idle(halt_in_idle), .consumers(consumers));
  cmp_far_model u_cmp_far_model (.clk(clk), .nrst(nrst),
    .analog_level(analog_level), .glitch_req(glitch_req),
    .raw_compare(raw_compare), .pwm_clk_tick(pwm_clk_tick));
  // Free-running clock, 50 ns period
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // Hang guard; whole run needs a few hundred cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      report_and_stop();
    end
  end
  task automatic report_and_stop;
    if (n_errors == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // One single word transfer; waits for ready in both phases
  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] rd);
    @(posedge clk);
    haddr  <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= wr;
    hsel   <= 1'b1;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    htrans <= 2'b00;
    hsel   <= 1'b0;
    hwdata <= wd;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    rd = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] unused;
    bus(1'b1, a, d, unused);
  endtask
  task automatic rd_chk(input string what, input logic [7:0] a,
                        input logic [31:0] e);
    logic [31:0] d;
    bus(1'b0, a, 32'h0, d);
    check(what, d, e);
  endtask
  // Level change launched at a rising edge
  task automatic set_level(input logic v);
    @(posedge clk);
    analog_level <= v;
  endtask
  // Clock cycles until irq reaches v; running past lim is a mismatch
  task automatic wait_irq(input logic v, input int lim, output int k);
    k = 0;
    while (k <= lim && consumers.irq !== v) begin
      @(negedge clk);
      k++;
    end
    check("irq wait", {31'h0, k > lim}, 32'h0);
  endtask
  task automatic t_reset;
    rd_chk("ctrl rst", ctrl_off, 32'h0);
    rd_chk("thr rst", threshold_off, 32'h0);
    rd_chk("stat rst", status_off, 32'h0);
    check("ready", {31'h0, hreadyout}, 32'h1);
    check("resp", {31'h0, hresp}, 32'h0);
  endtask
  task automatic t_regs;
    wr(ctrl_off, 32'hffff_7ff7);
    rd_chk("ctrl mask", ctrl_off, 32'h3ff7);
    wr(threshold_off, 32'hffff_fabc);
    rd_chk("thr", threshold_off, 32'habc);
    check("dac", {20'h0, analog_ctrl.dac_code}, 32'habc);
    check("halt", {31'h0, halt_in_idle}, 32'h1);
    check("off src", {26'h0, analog_ctrl.source_onehot}, 32'h0);
    wr(8'h0c, 32'h1234);
    rd_chk("unmapped", 8'h0c, 32'h0);
    wr(status_off, 32'h1);
    rd_chk("stat ro", status_off, 32'h0);
  endtask
  // Every source code with both alternate settings, fields varied alongside
  task automatic t_source;
    for (int i = 0; i < 8; i++) begin
      logic [2:0]  b;
      logic [31:0] c;
      b = 3'(i);
      c = 32'h8000 | (32'(b[2]) << alt_source_bit);
      c = c | (32'(b[1:0]) << source_sel_lsb) | (32'(b[0]) << ext_ref_bit);
      c = c | (32'(b[1]) << range_bit) | (32'(b[2]) << dac_oe_bit);
      c = c | (32'(b[1:0]) << hys_amount_lsb) | (32'(b[0]) << hys_edge_bit);
      wr(ctrl_off, c);
      @(negedge clk);  // Write lands on the edge the task returns on
      check("src", {26'h0, analog_ctrl.source_onehot},
            (i < 6) ? 32'(1 << i) : 32'h0);
      check("ext", {31'h0, analog_ctrl.ext_reference_select},
            {31'h0, b[0]});
      check("avdd", {31'h0, analog_ctrl.avdd_reference},
            {31'h0, ~b[0] & b[1]});
      check("dac_pin_output_enable", {31'h0, analog_ctrl.dac_pin_output_enable},
            {31'h0, b[2]});
      check("hys", {30'h0, analog_ctrl.hysteresis_amount_select},
            {30'h0, b[1:0]});
      check("hysedge", {31'h0, analog_ctrl.hysteresis_edge_select},
            {31'h0, b[0]});
    end
  endtask
  task automatic t_polarity;
    wr(ctrl_off, 32'h8000);
    set_level(1'b1);
    wait_irq(1'b1, 20, n);
    check("nofilt lat", {31'h0, n <= 5}, 32'h1);
    rd_chk("stat hi", status_off, 32'h1);
    rd_chk("ctrl state", ctrl_off, 32'h8008);
    check("fanout", {27'h0, consumers.irq, consumers.adc_trigger,
          consumers.pwm_duty_trunc, consumers.pwm_period_trunc,
          consumers.pwm_fault}, 32'h1f);
    check("no wake", {31'h0, consumers.wake}, 32'h0);
    @(posedge clk);
    sleep_mode <= 1'b1;
    @(negedge clk);
    check("wake", {31'h0, consumers.wake}, 32'h1);
    @(posedge clk);
    sleep_mode <= 1'b0;
    wr(ctrl_off, 32'h8002);
    wait_irq(1'b0, 20, n);
    rd_chk("stat inv", status_off, 32'h0);
    set_level(1'b0);
    wait_irq(1'b1, 20, n);
    check("inv lat", {31'h0, n <= 20}, 32'h1);
    wr(ctrl_off, 32'h0002);
    @(negedge clk);
    check("off out", {31'h0, consumers.irq}, 32'h0);
    rd_chk("off stat", status_off, 32'h0);
  endtask
  // Sub-cycle pulse must come out at least three clocks wide
  task automatic t_stretch;
    int hi;
    hi = 0;
    wr(ctrl_off, 32'h8000);
    @(posedge clk);
    glitch_req <= 1'b1;
    repeat (12) begin
      @(negedge clk);
      hi = hi + int'(consumers.irq === 1'b1);
    end
    check("stretch", {31'h0, hi >= 3}, 32'h1);
    glitch_req <= 1'b0;
  endtask
  // Latency with filter on the system clock, then on the PWM clock
  task automatic t_filter(input logic [31:0] c, input int lo,
                          input int hi);
    wr(ctrl_off, c);
    set_level(1'b1);
    wait_irq(1'b1, 100, n);
    check("filt lat", {31'h0, n >= lo && n <= hi}, 32'h1);
    set_level(1'b0);
    wait_irq(1'b0, 100, n);
  endtask
  task automatic t_idle(input logic [31:0] c, input logic other);
    wr(ctrl_off, c);
    set_level(1'b1);
    wait_irq(1'b1, 20, n);
    @(posedge clk);
    idle_mode <= 1'b1;
    other_halt_idle <= other;
    wait_irq(1'b0, 20, n);
    check("idle halt", {31'h0, consumers.irq}, 32'h0);
    check("idle ana", {31'h0, analog_ctrl.analog_enable}, 32'h0);
    @(posedge clk);
    idle_mode <= 1'b0;
    other_halt_idle <= 1'b0;
    set_level(1'b0);
  endtask
  initial begin
    nrst = 1'b0;
    analog_level = 1'b0;
    glitch_req = 1'b0;
    idle_mode = 1'b0;
    sleep_mode = 1'b0;
    other_halt_idle = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    n_errors = 0;
    total_checks = 0;
    cyc = 0;
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    t_reset();
    t_regs();
    t_source();
    t_polarity();
    t_stretch();
    t_filter(32'h8400, 5, 12);
    t_filter(32'h8600, 12, 80);
    t_idle(32'ha000, 1'b0);
    t_idle(32'h8000, 1'b1);
    report_and_stop();
  end
endmodule
